// file: logic/sfe_front_end.sv
// pin front end of a serial flash: select, lanes, pause, protect
// assumes I_SCLK from the host, mode 0 or 3, config stable while selected
`timescale 1ns/10ps
module sfe_front_end
  import sfe_pkg::*;
#(
  parameter int ADDR_W = `SFE_ADDR_BITS,
  parameter int PAGE_BYTES = `SFE_PAGE_BYTES
) (
  input wire logic I_CLK,
  input wire logic I_SRST,
  input wire logic I_SCLK,
  input wire logic I_CS_N,
  input wire logic [3:0] I_LANE,
  output logic [3:0] O_LANE,
  output logic [3:0] O_LANE_OE,
  input wire sfe_lane_mode_t I_LANE_MODE,
  input wire logic I_TX_EN,
  input wire logic I_QUAD_LANE_ENABLE,
  input wire logic I_STATUS_LOCK_BITS,
  input wire logic [2:0] I_BLOCK_GUARD,
  input wire logic I_WRITE_BUSY,
  input wire logic I_PROGRAM_DATA,
  input wire logic [7:0] I_TX_BYTE,
  input wire logic I_TX_VALID,
  output logic O_TX_READY,
  output logic [7:0] O_RX_BYTE,
  output logic O_RX_VALID,
  output logic O_SELECTED,
  output logic O_STANDBY,
  output logic O_PAGE_OVERFLOW,
  output logic O_QUAD_REFUSED,
  input wire logic I_ERASE_REQ,
  input wire sfe_erase_kind_t I_ERASE_KIND,
  input wire logic [ADDR_W-1:0] I_ERASE_ADDR,
  output logic O_ERASE_VALID,
  output logic [ADDR_W-1:0] O_ERASE_BASE,
  output logic [ADDR_W-1:0] O_ERASE_LAST,
  output logic O_STATUS_WRITE_BLOCKED,
  output logic O_ARRAY_HW_LOCKED
);
  // ----------------------------------------------------------------
  // shared state
  // ----------------------------------------------------------------
  sfe_cfg_t cfg_q;
  logic pause;
  logic link_clr;
  logic [3:0] step;
  logic [3:0] rx_bits;

  logic [7:0] rx_sr_q;
  logic [3:0] rx_cnt_q;
  logic [1:0][7:0] rx_slot_q;
  logic rx_tgl_q;
  logic [7:0] rx_next;
  logic rx_done;

  logic [7:0] tx_sr_q;
  logic [3:0] tx_cnt_q;
  logic tx_want_q;
  logic [3:0] tx_pins;
  logic [3:0] tx_oe;
  logic [1:0] tx_seen_meta_q;
  logic tx_seen_q;
  logic tx_ack_q;
  logic tx_load;

  logic [7:0] tx_hold_q;
  logic tx_tgl_q;
  logic tx_pend_q;

  logic [3:0] sync_in;
  logic [3:0] sync_out;
  logic cs_s;
  logic wp_n_s;
  logic rx_tgl_s;
  logic tx_ack_s;
  logic rx_tgl_last_q;
  logic tx_ack_last_q;
  logic seen_high_q;
  logic [8:0] page_cnt_q;
  logic page_full;

  // ----------------------------------------------------------------
  // link side, serial clock domain
  // ----------------------------------------------------------------
  // pause only exists while lane 3 is the pause pin
  assign pause = ~cfg_q.quad_lane_enable & ~I_LANE[3] & ~I_CS_N;
  assign link_clr = I_CS_N | pause;
  assign step = sfe_lane_step(cfg_q.mode);

  always_comb begin
    case (cfg_q.mode)
      LM_DUAL: rx_bits = {2'b00, I_LANE[1:0]};
      LM_QUAD: rx_bits = I_LANE;
      default: rx_bits = {3'b000, I_LANE[0]};
    endcase
  end

  always_comb begin
    case (cfg_q.mode)
      LM_DUAL: rx_next = {rx_sr_q[5:0], rx_bits[1:0]};
      LM_QUAD: rx_next = {rx_sr_q[3:0], rx_bits[3:0]};
      default: rx_next = {rx_sr_q[6:0], rx_bits[0]};
    endcase
  end

  assign rx_done = (rx_cnt_q + step) == 4'(`SFE_BYTE_BITS);

  // same edge use serves idle-low and idle-high clocks
  // deselect clears the shifter, so a new frame restarts at bit 0
  always_ff @(posedge I_SCLK or posedge I_CS_N) begin
    if (I_CS_N) begin
      rx_sr_q <= `SFE_RESET_BYTE;
      rx_cnt_q <= 4'h0;
    end else if (I_LANE[3] | cfg_q.quad_lane_enable) begin
      rx_sr_q <= rx_next;
      rx_cnt_q <= rx_done ? 4'h0 : rx_cnt_q + step;
    end
  end

  // byte hand-off toggle survives deselect; two slots give the
  // system side four lane periods to pick a byte up
  always_ff @(posedge I_SCLK or posedge I_SRST) begin
    if (I_SRST) begin
      rx_tgl_q <= 1'b0;
      rx_slot_q <= '0;
    end else if (~I_CS_N & (I_LANE[3] | cfg_q.quad_lane_enable) & rx_done) begin
      rx_slot_q[~rx_tgl_q] <= rx_next;
      rx_tgl_q <= ~rx_tgl_q;
    end
  end

  always_ff @(posedge I_SCLK or posedge I_SRST) begin
    if (I_SRST) begin
      tx_seen_meta_q <= 2'b00;
    end else begin
      tx_seen_meta_q <= {tx_seen_meta_q[0], tx_tgl_q};
    end
  end
  assign tx_seen_q = tx_seen_meta_q[1];

  assign tx_load = (tx_cnt_q == 4'h0) & cfg_q.tx_en & (tx_seen_q != tx_ack_q);

  always_ff @(negedge I_SCLK or posedge I_SRST) begin
    if (I_SRST) begin
      tx_ack_q <= 1'b0;
    end else if (~link_clr & tx_load) begin
      tx_ack_q <= ~tx_ack_q;
    end
  end

  always_ff @(negedge I_SCLK or posedge I_CS_N) begin
    if (I_CS_N) begin
      tx_sr_q <= `SFE_RESET_BYTE;
      tx_cnt_q <= 4'h0;
      tx_want_q <= 1'b0;
    end else if (~pause) begin
      if (tx_load) begin
        tx_sr_q <= tx_hold_q;
        tx_cnt_q <= 4'(`SFE_BYTE_BITS) - step;
        tx_want_q <= 1'b1;
      end else if (tx_cnt_q != 4'h0) begin
        tx_sr_q <= tx_sr_q << step;
        tx_cnt_q <= tx_cnt_q - step;
      end else begin
        tx_want_q <= 1'b0;
      end
    end
  end

  // next lane values: from the fresh word on a load, else the shifter
  always_comb begin
    logic [7:0] src;
    src = tx_load ? tx_hold_q : tx_sr_q << step;
    case (cfg_q.mode)
      LM_DUAL: begin
        tx_pins = {2'b00, src[7:6]};
        tx_oe = 4'b0011;
      end
      LM_QUAD: begin
        tx_pins = src[7:4];
        tx_oe = 4'b1111;
      end
      default: begin
        tx_pins = {2'b00, src[7], 1'b0};
        tx_oe = 4'b0010;
      end
    endcase
  end

  // pins change only on falling edges; deselect or pause floats them
  always_ff @(negedge I_SCLK or posedge link_clr) begin
    if (link_clr) begin
      O_LANE <= 4'h0;
      O_LANE_OE <= 4'h0;
    end else if (tx_load | (tx_cnt_q != 4'h0)) begin
      O_LANE <= tx_pins;
      O_LANE_OE <= tx_oe;
    end else begin
      O_LANE <= 4'h0;
      O_LANE_OE <= 4'h0;
    end
  end

  // ----------------------------------------------------------------
  // system side, I_CLK domain
  // ----------------------------------------------------------------
  assign sync_in = {tx_ack_q, rx_tgl_q, I_LANE[2], I_CS_N};

  sfe_sync #(
    .WIDTH(4)
  ) u_sync (
    .i_clk(I_CLK),
    .i_srst(I_SRST),
    .i_async(sync_in),
    .o_sync(sync_out)
  );

  assign cs_s = sync_out[0];
  assign wp_n_s = sync_out[1];
  assign rx_tgl_s = sync_out[2];
  assign tx_ack_s = sync_out[3];

  // settings are only taken while deselected
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      cfg_q <= '{mode: LM_SINGLE, tx_en: 1'b0, quad_lane_enable: 1'b0};
      O_QUAD_REFUSED <= 1'b0;
    end else if (cs_s) begin
      cfg_q.quad_lane_enable <= I_QUAD_LANE_ENABLE;
      cfg_q.tx_en <= I_TX_EN;
      if (I_LANE_MODE == LM_QUAD && !I_QUAD_LANE_ENABLE) begin
        cfg_q.mode <= LM_SINGLE;
        O_QUAD_REFUSED <= 1'b1;
      end else begin
        cfg_q.mode <= I_LANE_MODE;
        O_QUAD_REFUSED <= 1'b0;
      end
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      seen_high_q <= 1'b0;
      O_SELECTED <= 1'b0;
      O_STANDBY <= 1'b0;
    end else begin
      if (cs_s) begin
        seen_high_q <= 1'b1;
      end
      O_SELECTED <= ~cs_s & seen_high_q;
      O_STANDBY <= cs_s & ~I_WRITE_BUSY;
    end
  end

  assign page_full = page_cnt_q >= 9'(PAGE_BYTES);

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      rx_tgl_last_q <= 1'b0;
      O_RX_BYTE <= `SFE_RESET_BYTE;
      O_RX_VALID <= 1'b0;
      page_cnt_q <= 9'h000;
      O_PAGE_OVERFLOW <= 1'b0;
    end else begin
      rx_tgl_last_q <= rx_tgl_s;
      O_RX_VALID <= 1'b0;
      if (cs_s) begin
        page_cnt_q <= 9'h000;
        O_PAGE_OVERFLOW <= 1'b0;
      end else if ((rx_tgl_s != rx_tgl_last_q) && seen_high_q) begin
        if (I_PROGRAM_DATA && page_full) begin
          O_PAGE_OVERFLOW <= 1'b1;
        end else begin
          O_RX_BYTE <= rx_slot_q[rx_tgl_s];
          O_RX_VALID <= 1'b1;
          if (I_PROGRAM_DATA) begin
            page_cnt_q <= page_cnt_q + 9'h001;
          end
        end
      end
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      tx_hold_q <= `SFE_RESET_BYTE;
      tx_tgl_q <= 1'b0;
      tx_pend_q <= 1'b0;
      tx_ack_last_q <= 1'b0;
      O_TX_READY <= 1'b0;
    end else begin
      tx_ack_last_q <= tx_ack_s;
      if (I_TX_VALID && O_TX_READY) begin
        tx_hold_q <= I_TX_BYTE;
        tx_tgl_q <= ~tx_tgl_q;
        tx_pend_q <= 1'b1;
        O_TX_READY <= 1'b0;
      end else if (tx_ack_s != tx_ack_last_q) begin
        tx_pend_q <= 1'b0;
        O_TX_READY <= 1'b1;
      end else begin
        O_TX_READY <= ~tx_pend_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // protection and erase span
  // ----------------------------------------------------------------
  sfe_guard #(
    .ADDR_W(ADDR_W)
  ) u_guard (
    .i_clk(I_CLK),
    .i_srst(I_SRST),
    .i_wp_n_s(wp_n_s),
    .i_quad_lane_enable(cfg_q.quad_lane_enable),
    .i_status_lock_bits(I_STATUS_LOCK_BITS),
    .i_block_guard(I_BLOCK_GUARD),
    .i_erase_req(I_ERASE_REQ),
    .i_erase_kind(I_ERASE_KIND),
    .i_erase_addr(I_ERASE_ADDR),
    .o_status_write_blocked(O_STATUS_WRITE_BLOCKED),
    .o_array_hw_locked(O_ARRAY_HW_LOCKED),
    .o_erase_valid(O_ERASE_VALID),
    .o_erase_base(O_ERASE_BASE),
    .o_erase_last(O_ERASE_LAST)
  );
endmodule

// file: shared/sfe_map.svh
// offsets, sizes and field positions for the serial flash pin front end
// assumes inclusion by bare name from package and modules
`ifndef SFE_MAP_SVH
`define SFE_MAP_SVH

`define SFE_BYTE_BITS 8
`define SFE_PAGE_BYTES 256
`define SFE_ADDR_BITS 23
`define SFE_SECTOR_LOG 12
`define SFE_BLOCK32_LOG 15
`define SFE_BLOCK64_LOG 16
`define SFE_RESET_BYTE 8'h00

`endif

// file: shared/sfe_pkg.sv
// types shared by the serial flash pin front end
// assumes sfe_map.svh is on the include path
package sfe_pkg;
  `include "sfe_map.svh"

  typedef enum logic [1:0] {
    LM_SINGLE = 2'b00,
    LM_DUAL   = 2'b01,
    LM_QUAD   = 2'b10
  } sfe_lane_mode_t;

  typedef enum logic [1:0] {
    EK_SECTOR  = 2'b00,
    EK_BLOCK32 = 2'b01,
    EK_BLOCK64 = 2'b10,
    EK_CHIP    = 2'b11
  } sfe_erase_kind_t;

  // frame settings, frozen while the device is selected
  typedef struct packed {
    sfe_lane_mode_t mode;
    logic tx_en;
    logic quad_lane_enable;
  } sfe_cfg_t;

  // bits moved per serial clock edge for a lane mode
  function automatic logic [3:0] sfe_lane_step(input sfe_lane_mode_t m);
    case (m)
      LM_DUAL: sfe_lane_step = 4'h2;
      LM_QUAD: sfe_lane_step = 4'h4;
      default: sfe_lane_step = 4'h1;
    endcase
  endfunction
endpackage

// file: logic/sfe_sync.sv
// two flip-flop synchroniser for a group of levels
// assumes each bit changes independently and slowly
`timescale 1ns/10ps
module sfe_sync #(
  parameter int WIDTH = 1
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      meta_q <= '0;
      o_sync <= '0;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule

// file: logic/sfe_guard.sv
// write protect and erase span logic of the serial flash front end
// assumes synchronised protect pin and system clock inputs
`timescale 1ns/10ps
module sfe_guard
  import sfe_pkg::*;
#(
  parameter int ADDR_W = `SFE_ADDR_BITS
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_wp_n_s,
  input wire logic i_quad_lane_enable,
  input wire logic i_status_lock_bits,
  input wire logic [2:0] i_block_guard,
  input wire logic i_erase_req,
  input wire sfe_erase_kind_t i_erase_kind,
  input wire logic [ADDR_W-1:0] i_erase_addr,
  output logic o_status_write_blocked,
  output logic o_array_hw_locked,
  output logic o_erase_valid,
  output logic [ADDR_W-1:0] o_erase_base,
  output logic [ADDR_W-1:0] o_erase_last
);
  logic hw_block;
  logic [ADDR_W-1:0] span_mask;

  // pin counts only while it is not a data lane
  assign hw_block = i_status_lock_bits & ~i_wp_n_s & ~i_quad_lane_enable;

  function automatic logic [ADDR_W-1:0] span_of(input sfe_erase_kind_t k);
    case (k)
      EK_SECTOR: span_of = ADDR_W'((1 << `SFE_SECTOR_LOG) - 1);
      EK_BLOCK32: span_of = ADDR_W'((1 << `SFE_BLOCK32_LOG) - 1);
      EK_BLOCK64: span_of = ADDR_W'((1 << `SFE_BLOCK64_LOG) - 1);
      default: span_of = '1;
    endcase
  endfunction

  assign span_mask = span_of(i_erase_kind);

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_status_write_blocked <= 1'b0;
      o_array_hw_locked <= 1'b0;
    end else begin
      o_status_write_blocked <= hw_block;
      o_array_hw_locked <= hw_block & (|i_block_guard);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_erase_valid <= 1'b0;
      o_erase_base <= '0;
      o_erase_last <= '0;
    end else begin
      o_erase_valid <= i_erase_req;
      if (i_erase_req) begin
        o_erase_base <= i_erase_addr & ~span_mask;
        o_erase_last <= i_erase_addr | span_mask;
      end
    end
  end
endmodule

// file: verif/sfe_props.sv
// checker of the flash pin front end
// assumes a bind onto sfe_front_end
`timescale 1ns/10ps
module sfe_props
  import sfe_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_SRST,
  input wire logic I_CS_N,
  input wire logic [3:0] I_LANE,
  input wire logic [3:0] O_LANE_OE,
  input wire sfe_lane_mode_t I_LANE_MODE,
  input wire logic I_QUAD_LANE_ENABLE,
  input wire logic I_STATUS_LOCK_BITS,
  input wire logic [2:0] I_BLOCK_GUARD,
  input wire logic I_WRITE_BUSY,
  input wire logic O_RX_VALID,
  input wire logic O_SELECTED,
  input wire logic O_STANDBY,
  input wire logic I_ERASE_REQ,
  input wire logic O_ERASE_VALID,
  input wire logic O_STATUS_WRITE_BLOCKED,
  input wire logic O_ARRAY_HW_LOCKED
);
  // ----
  // pin relations
  // ----
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_SRST);
  sequence guard_on_s;
    (I_STATUS_LOCK_BITS && !I_LANE[2] && !I_QUAD_LANE_ENABLE)[*5];
  endsequence
  sequence paused_s;
    (!I_CS_N && !I_LANE[3] && !I_QUAD_LANE_ENABLE)[*2];
  endsequence
  desel_float_a: assert property (I_CS_N |-> O_LANE_OE == 4'h0)
    else $error("lanes driven while deselected");
  standby_on_a: assert property ((I_CS_N && !I_WRITE_BUSY)[*6] |-> O_STANDBY)
    else $error("no standby while idle");
  busy_wake_a: assert property (I_WRITE_BUSY[*2] |-> !O_STANDBY)
    else $error("standby during write cycle");
  select_on_a: assert property ((!I_CS_N)[*6] |-> !O_STANDBY && O_SELECTED)
    else $error("not selected");
  pause_float_a: assert property (paused_s |-> O_LANE_OE == 4'h0)
    else $error("lanes driven in pause");
  one_lane_a: assert property (!I_CS_N && I_LANE_MODE != LM_DUAL &&
    !(I_LANE_MODE == LM_QUAD && I_QUAD_LANE_ENABLE) |-> O_LANE_OE inside {4'h0, 4'h2})
    else $error("extra lanes driven");
  rx_pulse_a: assert property (O_RX_VALID |=> !O_RX_VALID)
    else $error("rx valid too long");
  erase_ack_a: assert property (I_ERASE_REQ |=> O_ERASE_VALID)
    else $error("erase not answered");
  guard_on_a: assert property (guard_on_s |-> O_STATUS_WRITE_BLOCKED)
    else $error("status write not blocked");
  quad_free_a: assert property (I_QUAD_LANE_ENABLE[*6] |->
    !O_STATUS_WRITE_BLOCKED && !O_ARRAY_HW_LOCKED)
    else $error("protect active with quad");
  lock_span_a: assert property ((I_BLOCK_GUARD == 3'h0)[*2] |-> !O_ARRAY_HW_LOCKED)
    else $error("array locked without guard");
endmodule

bind sfe_front_end sfe_props u_props (
  .I_CLK(I_CLK), .I_SRST(I_SRST), .I_CS_N(I_CS_N), .I_LANE(I_LANE),
  .O_LANE_OE(O_LANE_OE), .I_LANE_MODE(I_LANE_MODE),
  .I_QUAD_LANE_ENABLE(I_QUAD_LANE_ENABLE), .I_STATUS_LOCK_BITS(I_STATUS_LOCK_BITS),
  .I_BLOCK_GUARD(I_BLOCK_GUARD), .I_WRITE_BUSY(I_WRITE_BUSY), .O_RX_VALID(O_RX_VALID),
  .O_SELECTED(O_SELECTED), .O_STANDBY(O_STANDBY), .I_ERASE_REQ(I_ERASE_REQ),
  .O_ERASE_VALID(O_ERASE_VALID), .O_STATUS_WRITE_BLOCKED(O_STATUS_WRITE_BLOCKED),
  .O_ARRAY_HW_LOCKED(O_ARRAY_HW_LOCKED)
);

// file: verif/sfe_host_model.sv
// host serial master model, clock mode 0, 32 ns serial clock
// assumes the bench calls sel, xfer and desel in order
`timescale 1ns/10ps
module sfe_host_model (
  output logic o_sclk,
  output logic o_cs_n,
  output logic [3:0] o_lane,
  input wire logic [3:0] i_dut,
  input wire logic [3:0] i_oe,
  input wire logic i_wp_n
);
  logic [3:0] drv;
  logic [3:0] val;
  logic pause_n;
  logic idle;
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b0;
    drv = 4'h0;
    val = 4'h0;
    pause_n = 1'b1;
    idle = 1'b0;
    // a real rising edge clears the link shifters before any frame
    #1 o_cs_n = 1'b1;
  end
  // ----
  // wire levels: pull-ups on protect and pause, toggling elsewhere
  // ----
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      if (i_oe[k])
        o_lane[k] = i_dut[k];
      else if (drv[k])
        o_lane[k] = val[k];
      else
        o_lane[k] = (k == 2) ? i_wp_n : (k == 3) ? pause_n : idle ^ k[0];
    end
  end
  task automatic pulse(input logic [3:0] v, input logic [3:0] m, output logic [3:0] s);
    drv = m;
    val = v;
    idle = ~idle;
    #16 o_sclk = 1'b1;
    s = o_lane;
    #16 o_sclk = 1'b0;
  endtask
  task automatic hold_pause();
    #8 pause_n = 1'b0;
    val = ~val;
    repeat (2) begin
      #16 o_sclk = 1'b1;
      #16 o_sclk = 1'b0;
    end
    #8 pause_n = 1'b1;
  endtask
  task automatic xfer(input logic [7:0] tx, input int st, input bit rd, input int hold_at,
                      output logic [7:0] rx);
    logic [7:0] t;
    logic [3:0] s;
    rx = 8'h00;
    for (int n = 0; n < 8; n += st) begin
      if (n == hold_at)
        hold_pause();
      t = tx << n;
      pulse(t[7:4] >> (4 - st), rd ? 4'h0 : 4'((1 << st) - 1), s);
      rx = (rx << st) | 8'(st == 4 ? s : st == 2 ? s[1:0] : s[1]);
    end
  endtask
  task automatic sel();
    #100 o_cs_n = 1'b0;
    #20;
  endtask
  task automatic desel();
    #20 o_cs_n = 1'b1;
    drv = 4'h0;
    #200;
  endtask
endmodule

// file: verif/tb_serial_flash_pin_front_end.sv
// self-checking bench of the flash pin front end
// assumes sfe_host_model as the host and sfe_props bound to the design
`timescale 1ns/10ps
module tb_serial_flash_pin_front_end;
  import sfe_pkg::*;
  logic I_CLK = 1'b0;
  logic I_SRST, I_SCLK, I_CS_N, I_TX_EN, I_QUAD_LANE_ENABLE, I_STATUS_LOCK_BITS;
  logic I_WRITE_BUSY, I_PROGRAM_DATA, I_TX_VALID, I_ERASE_REQ, O_TX_READY, O_RX_VALID;
  logic O_SELECTED, O_STANDBY, O_PAGE_OVERFLOW, O_QUAD_REFUSED, O_ERASE_VALID;
  logic O_STATUS_WRITE_BLOCKED, O_ARRAY_HW_LOCKED, wp_n;
  logic [3:0] I_LANE, O_LANE, O_LANE_OE;
  logic [2:0] I_BLOCK_GUARD;
  logic [7:0] I_TX_BYTE, O_RX_BYTE, r;
  logic [22:0] I_ERASE_ADDR, O_ERASE_BASE, O_ERASE_LAST, m;
  logic [31:0] lfsr = 32'hBEA0;
  logic [31:0] v;
  sfe_lane_mode_t I_LANE_MODE;
  sfe_erase_kind_t I_ERASE_KIND;
  int errors, comparisons;
  logic [7:0] rxq[$];
  sfe_front_end u_dut (.I_CLK(I_CLK), .I_SRST(I_SRST), .I_SCLK(I_SCLK), .I_CS_N(I_CS_N),
    .I_LANE(I_LANE), .O_LANE(O_LANE), .O_LANE_OE(O_LANE_OE), .I_LANE_MODE(I_LANE_MODE),
    .I_TX_EN(I_TX_EN), .I_QUAD_LANE_ENABLE(I_QUAD_LANE_ENABLE), .I_WRITE_BUSY(I_WRITE_BUSY),
    .I_STATUS_LOCK_BITS(I_STATUS_LOCK_BITS), .I_BLOCK_GUARD(I_BLOCK_GUARD),
    .I_PROGRAM_DATA(I_PROGRAM_DATA), .I_TX_BYTE(I_TX_BYTE), .I_TX_VALID(I_TX_VALID),
    .O_TX_READY(O_TX_READY), .O_RX_BYTE(O_RX_BYTE), .O_RX_VALID(O_RX_VALID),
    .O_SELECTED(O_SELECTED), .O_STANDBY(O_STANDBY), .O_PAGE_OVERFLOW(O_PAGE_OVERFLOW),
    .O_QUAD_REFUSED(O_QUAD_REFUSED), .I_ERASE_REQ(I_ERASE_REQ), .I_ERASE_KIND(I_ERASE_KIND),
    .I_ERASE_ADDR(I_ERASE_ADDR), .O_ERASE_VALID(O_ERASE_VALID), .O_ERASE_BASE(O_ERASE_BASE),
    .O_ERASE_LAST(O_ERASE_LAST), .O_STATUS_WRITE_BLOCKED(O_STATUS_WRITE_BLOCKED),
    .O_ARRAY_HW_LOCKED(O_ARRAY_HW_LOCKED));
  sfe_host_model u_host (.o_sclk(I_SCLK), .o_cs_n(I_CS_N), .o_lane(I_LANE), .i_dut(O_LANE),
    .i_oe(O_LANE_OE), .i_wp_n(wp_n));
  // ----
  // clock, capture and helpers
  // ----
  always #10 I_CLK = ~I_CLK;
  always @(posedge I_CLK) begin
    if (O_RX_VALID === 1'b1)
      rxq.push_back(O_RX_BYTE);
  end
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  function automatic logic [22:0] span(input sfe_erase_kind_t k);
    return k == EK_SECTOR ? 23'h000FFF : k == EK_BLOCK32 ? 23'h007FFF :
           k == EK_BLOCK64 ? 23'h00FFFF : 23'h7FFFFF;
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    if (errors == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge I_CLK);
    #1;
  endtask
  task automatic read_frame(input sfe_lane_mode_t md, input int st, input logic [7:0] cmd,
                            input logic [7:0] tx);
    int k;
    tick(1);
    I_LANE_MODE = md;
    rxq.delete();
    u_host.sel();
    u_host.xfer(cmd, st, 1'b0, 8, r);
    check("quad refused", O_QUAD_REFUSED, md == LM_QUAD && !I_QUAD_LANE_ENABLE);
    check("standby", O_STANDBY, 0);
    tick(1);
    for (k = 0; k < 50 && O_TX_READY !== 1'b1; k++)
      tick(1);
    if (k == 50) begin
      errors++;
      close_out();
    end
    I_TX_BYTE = tx;
    I_TX_VALID = 1'b1;
    tick(1);
    I_TX_VALID = 1'b0;
    // two idle clocks carry the reply byte into the link domain
    u_host.xfer(8'h00, 4, 1'b1, 8, r);
    u_host.xfer(8'h00, st, 1'b1, 8, r);
    #1 check("lanes idle", O_LANE_OE, 0);
    u_host.desel();
    check("rx byte", rxq[0], cmd);
    check("tx byte", r, tx);
  endtask
  // ----
  // main sequence
  // ----
  initial begin
    {I_SRST, I_TX_EN, wp_n} = 3'b011;
    {I_QUAD_LANE_ENABLE, I_STATUS_LOCK_BITS, I_WRITE_BUSY, I_PROGRAM_DATA} = 4'h0;
    {I_TX_VALID, I_ERASE_REQ, I_BLOCK_GUARD, I_TX_BYTE, I_ERASE_ADDR} = '0;
    I_LANE_MODE = LM_SINGLE;
    I_ERASE_KIND = EK_SECTOR;
    // a real rising edge reaches the link flops
    #1 I_SRST = 1'b1;
    tick(2);
    I_SRST = 1'b0;
    tick(6);
    I_WRITE_BUSY = 1'b1;
    tick(4);
    check("busy standby", O_STANDBY, 0);
    I_WRITE_BUSY = 1'b0;
    tick(4);
    check("idle standby", O_STANDBY, 1);
    for (int i = 0; i < 10; i++) begin
      v = rnd();
      I_QUAD_LANE_ENABLE = (i % 4 == 2);
      read_frame(sfe_lane_mode_t'(i % 4 == 3 ? 2 : i % 4), i % 4 == 1 ? 2 : i % 4 == 2 ? 4 : 1,
                 v[7:0], v[15:8]);
    end
    I_QUAD_LANE_ENABLE = 1'b1;
    read_frame(LM_QUAD, 4, 8'h00, 8'hFF);
    I_QUAD_LANE_ENABLE = 1'b0;
    tick(1);
    I_LANE_MODE = LM_SINGLE;
    rxq.delete();
    u_host.sel();
    u_host.xfer(8'hA5, 1, 1'b0, 4, r);
    u_host.desel();
    check("paused byte", rxq[0], 8'hA5);
    I_QUAD_LANE_ENABLE = 1'b1;
    {I_PROGRAM_DATA, I_TX_EN} = 2'b10;
    I_LANE_MODE = LM_QUAD;
    rxq.delete();
    u_host.sel();
    for (int k = 0; k < 257; k++)
      u_host.xfer(8'(k), 4, 1'b0, 8, r);
    tick(6);
    check("overflow", O_PAGE_OVERFLOW, 1);
    u_host.desel();
    check("page bytes", rxq.size(), 256);
    check("last page byte", rxq[255], 8'hFF);
    check("overflow clear", O_PAGE_OVERFLOW, 0);
    for (int i = 0; i < 16; i++) begin
      v = rnd();
      {I_STATUS_LOCK_BITS, wp_n, I_QUAD_LANE_ENABLE, I_BLOCK_GUARD} = v[5:0];
      tick(8);
      check("blocked", O_STATUS_WRITE_BLOCKED, v[5] & ~v[4] & ~v[3]);
      check("hw locked", O_ARRAY_HW_LOCKED, v[5] & ~v[4] & ~v[3] & |v[2:0]);
    end
    for (int k = 0; k < 4; k++) begin
      v = rnd();
      I_ERASE_KIND = sfe_erase_kind_t'(k);
      I_ERASE_ADDR = v[22:0];
      m = span(I_ERASE_KIND);
      I_ERASE_REQ = 1'b1;
      tick(1);
      I_ERASE_REQ = 1'b0;
      check("erase base", O_ERASE_BASE, v[22:0] & ~m);
      check("erase last", O_ERASE_LAST, v[22:0] | m);
    end
    close_out();
  end
  initial begin
    #1000000;
    errors++;
    close_out();
  end
endmodule
